/* File: rtl/vfd_detector.sv */
// Video format detector: payload id capture, raster measurement, format
`timescale 1ns/1ns

// Functional notes
// R1: Capture four payload words into 0Fh and 10h
// R2: Version flag follows captured packet version bit
// R3: Update only when received checksum matches local
// R4: Ignore packets on the wrong video line
// R5: Clear payload bytes on reset, unlock, bypass
// R6: Measure line and frame geometry from TRS
// R7: Lines in 11-bit, words in 13-bit fields
// R8: Sync flag high only after flywheel locks
// R9: Clear raster and sync flag likewise
// R10: Format code: SDTI 0-5, SDI 6, ASI 7; codes 0-5 are never produced
// R11: Format code Fh on reset, unlock, both low
// R12: Sync bit 4, format bits 3-0 at 04h
// R13: All four payload bytes written together
module vfd_detector #(
  parameter int SYNC_FRAMES = 2
) (
  input  wire logic        mclk,                    // Word clock
  input  wire logic        rst_b,                   // Async reset, low
  input  wire logic        vid_en,                  // Word strobe
  input  wire logic [9:0]  vid_data,                // Received word
  input  wire logic        locked,                  // Input lock
  input  wire logic        video_processing_select, // Low bypasses
  input  wire logic        async_serial_select,     // ASI selected
  input  wire logic        reg_rd,                  // Read strobe
  input  wire logic [7:0]  reg_addr,                // Register address
  output logic      [15:0] reg_rdata,               // Read data
  output logic             reg_rvalid,              // Read data valid
  output logic             raster_sync_flag         // Flywheel synced
);
  import vfd_pkg::*;

  initial
  begin
    if (SYNC_FRAMES < 1 || SYNC_FRAMES > 15)
      $error("SYNC_FRAMES must be 1 to 15");
  end

  // ****************************************************************
  // Stream framing
  // ****************************************************************
  logic [9:0]  w1_reg, w2_reg;
  logic        trs_pend_reg, anc_pend_reg;
  logic        clr, fmt_clr, eav_ev, sav_ev, frame_start, vblank_start;
  logic        f_prev_reg, v_prev_reg;

  assign clr     = !locked || !video_processing_select;
  assign fmt_clr = !locked || (!video_processing_select
                               && !async_serial_select);
  assign eav_ev  = vid_en && trs_pend_reg && vid_data[XYZ_H];
  assign sav_ev  = vid_en && trs_pend_reg && !vid_data[XYZ_H];
  assign frame_start  = eav_ev && f_prev_reg && !vid_data[XYZ_F];
  assign vblank_start = eav_ev && !v_prev_reg && vid_data[XYZ_V];

  // Preamble history; the id word or DID follows the third word
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      w1_reg       <= W_ZERO;
      w2_reg       <= W_ZERO;
      trs_pend_reg <= 1'b0;
      anc_pend_reg <= 1'b0;
    end
    else if (vid_en)
    begin
      w1_reg       <= vid_data;
      w2_reg       <= w1_reg;
      trs_pend_reg <= w2_reg == W_ONES && w1_reg == W_ZERO
                      && vid_data == W_ZERO;
      anc_pend_reg <= w2_reg == W_ZERO && w1_reg == W_ONES
                      && vid_data == W_ONES;
    end
  end

  // ****************************************************************
  // Raster measurement
  // ****************************************************************
  logic [12:0] wcnt_reg, sav_pos_reg;
  logic [10:0] lcnt_reg, acnt_reg;
  logic        words_mis_reg;
  logic [3:0]  match_cnt_reg;
  vfd_raster_t raster_reg;

  // Word position in the line, EAV id word counted as 1 so the value
  // seen at the next EAV id word is the whole line length
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      wcnt_reg <= 13'h0000;
    else if (eav_ev)
      wcnt_reg <= 13'h0001;
    else if (vid_en)
      wcnt_reg <= wcnt_reg + 13'h0001;
  end

  // Field flag history for frame and blanking edges
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      f_prev_reg  <= 1'b0;
      v_prev_reg  <= 1'b0;
      sav_pos_reg <= 13'h0000;
    end
    else
    begin
      if (eav_ev)
      begin
        f_prev_reg <= vid_data[XYZ_F];
        v_prev_reg <= vid_data[XYZ_V];
      end
      if (sav_ev)
        sav_pos_reg <= wcnt_reg;
    end
  end

  // Geometry capture; a bypass or unlock wipes it
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      raster_reg    <= '0;
      lcnt_reg      <= 11'h000;
      acnt_reg      <= 11'h000;
      words_mis_reg <= 1'b0;
    end
    else if (clr)
    begin
      raster_reg    <= '0;                           // R9
      lcnt_reg      <= 11'h000;
      acnt_reg      <= 11'h000;
      words_mis_reg <= 1'b0;
    end
    else if (eav_ev)
    begin
      raster_reg.total_words  <= wcnt_reg;           // R6
      raster_reg.active_words <= wcnt_reg - sav_pos_reg - ACT_OFFSET;
      if (wcnt_reg != raster_reg.total_words)
        words_mis_reg <= 1'b1;
      if (frame_start)
      begin
        raster_reg.total_lines <= lcnt_reg;          // R7
        lcnt_reg      <= 11'h001;
        words_mis_reg <= 1'b0;
      end
      else
        lcnt_reg <= lcnt_reg + 11'h001;
      if (vblank_start)
      begin
        raster_reg.active_lines <= acnt_reg;         // R6
        acnt_reg <= 11'h000;
      end
      else if (!vid_data[XYZ_V])
        acnt_reg <= acnt_reg + 11'h001;
    end
  end

  // Flywheel: frames with unchanged geometry in a row
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      match_cnt_reg    <= 4'h0;
      raster_sync_flag <= 1'b0;
    end
    else if (clr)
    begin
      match_cnt_reg    <= 4'h0;
      raster_sync_flag <= 1'b0;                      // R9
    end
    else if (frame_start)
    begin
      if (lcnt_reg == raster_reg.total_lines && !words_mis_reg)
      begin
        if (match_cnt_reg != 4'(SYNC_FRAMES))
          match_cnt_reg <= match_cnt_reg + 4'h1;
        // Compare the count before the increment, so the flag rises at the SYNC_FRAMES-th matching frame start
        raster_sync_flag <= match_cnt_reg
                            >= 4'(SYNC_FRAMES - 1);  // R8
      end
      else
      begin
        match_cnt_reg    <= 4'h0;
        raster_sync_flag <= 1'b0;                    // R8
      end
    end
  end

  // ****************************************************************
  // Payload identifier parser
  // ****************************************************************
  vfd_anc_t    anc_state;
  logic [8:0]  cs_sum_reg;
  logic        is_pid_reg;
  logic [7:0]  udw_left_reg;
  logic [1:0]  idx_reg;
  logic [7:0]  buf_reg [4];
  logic [15:0] pid_low_reg, pid_high_reg;
  logic        pid_ver_reg, cs_ok, line_ok, pid_wr;

  assign cs_ok   = vid_data[8:0] == cs_sum_reg
                   && vid_data[9] == !vid_data[8];   // R3
  assign line_ok = (raster_reg.total_lines == LINES_625)
                   ? (lcnt_reg == PID_L625_F1 || lcnt_reg == PID_L625_F2)
                   : (lcnt_reg == PID_L525_F1
                      || lcnt_reg == PID_L525_F2);   // R4
  assign pid_wr  = vid_en && anc_state == ANC_CS && is_pid_reg
                   && cs_ok && line_ok;

  // Packet walk with running 9-bit checksum
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      anc_state    <= ANC_IDLE;
      cs_sum_reg   <= 9'h000;
      is_pid_reg   <= 1'b0;
      udw_left_reg <= 8'h00;
      idx_reg      <= 2'h0;
      for (int i = 0; i < 4; i++)
        buf_reg[i] <= 8'h00;
    end
    else if (vid_en)
    begin
      unique case (anc_state)
        ANC_IDLE:
        begin
          if (anc_pend_reg)
          begin
            cs_sum_reg <= vid_data[8:0];
            is_pid_reg <= vid_data[7:0] == PID_DID;
            anc_state  <= ANC_SDID;
          end
        end
        ANC_SDID:
        begin
          cs_sum_reg <= cs_sum_reg + vid_data[8:0];
          is_pid_reg <= is_pid_reg && vid_data[7:0] == PID_SDID;
          anc_state  <= ANC_DC;
        end
        ANC_DC:
        begin
          cs_sum_reg   <= cs_sum_reg + vid_data[8:0];
          is_pid_reg   <= is_pid_reg && vid_data[7:0] == PID_DC;
          udw_left_reg <= vid_data[7:0];
          idx_reg      <= 2'h0;
          anc_state    <= (vid_data[7:0] == 8'h00) ? ANC_CS : ANC_UDW;
        end
        ANC_UDW:
        begin
          cs_sum_reg       <= cs_sum_reg + vid_data[8:0];
          buf_reg[idx_reg] <= vid_data[7:0];         // R1
          idx_reg          <= idx_reg + 2'h1;
          udw_left_reg     <= udw_left_reg - 8'h01;
          if (udw_left_reg == 8'h01)
            anc_state <= ANC_CS;
        end
        ANC_CS:
          anc_state <= ANC_IDLE;
      endcase
    end
  end

  // All four bytes in one edge so a read never mixes packets
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      pid_low_reg  <= REG_RESET;
      pid_high_reg <= REG_RESET;
      pid_ver_reg  <= 1'b0;
    end
    else if (clr)
    begin
      pid_low_reg  <= REG_RESET;                     // R5
      pid_high_reg <= REG_RESET;
      pid_ver_reg  <= 1'b0;
    end
    else if (pid_wr)
    begin
      pid_low_reg  <= {buf_reg[1], buf_reg[0]};      // R13
      pid_high_reg <= {buf_reg[3], buf_reg[2]};      // R1
      pid_ver_reg  <= buf_reg[0][PID_VER_BIT];       // R2
    end
  end

  // ****************************************************************
  // Data format and register read port
  // ****************************************************************
  logic [3:0] fmt_reg;

  // No SDTI header decoding, so codes 0h-5h are never produced
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      fmt_reg <= FMT_UNKNOWN;
    else if (fmt_clr)
      fmt_reg <= FMT_UNKNOWN;                        // R11
    else if (async_serial_select)
      fmt_reg <= FMT_ASI;                            // R10
    else if (raster_sync_flag)
      fmt_reg <= FMT_SDI;                            // R10
    else
      fmt_reg <= FMT_UNKNOWN;
  end

  // Read data one edge after the strobe; unmapped reads give zero
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata  <= REG_RESET;
      reg_rvalid <= 1'b0;
    end
    else
    begin
      reg_rvalid <= reg_rd;
      if (reg_rd)
      begin
        reg_rdata <= REG_RESET;
        unique case (reg_addr)
          ADDR_DATA_FORMAT:
          begin
            reg_rdata[DF_VER_BIT]  <= pid_ver_reg;
            reg_rdata[DF_SYNC_BIT] <= raster_sync_flag; // R12
            reg_rdata[3:0]         <= fmt_reg;          // R12
          end
          ADDR_PID_LOW:   reg_rdata <= pid_low_reg;
          ADDR_PID_HIGH:  reg_rdata <= pid_high_reg;
          ADDR_TOT_LINES: reg_rdata[10:0] <= raster_reg.total_lines;
          ADDR_TOT_WORDS: reg_rdata[12:0] <= raster_reg.total_words;
          ADDR_ACT_WORDS: reg_rdata[12:0] <= raster_reg.active_words;
          ADDR_ACT_LINES: reg_rdata[10:0] <= raster_reg.active_lines;
          default:        reg_rdata <= REG_RESET;
        endcase
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  sequence s_pid_take;
    pid_wr && !clr;
  endsequence
  property p_pid_capture;
    s_pid_take |=> pid_high_reg == {$past(buf_reg[3]), $past(buf_reg[2])}
                   && pid_low_reg == {$past(buf_reg[1]), $past(buf_reg[0])};
  endproperty
  a_pid_capture: assert property (p_pid_capture) // R1
    else $error("payload bytes not captured");
  property p_pid_version;
    s_pid_take |=> pid_ver_reg == $past(buf_reg[0][PID_VER_BIT]);
  endproperty
  a_pid_version: assert property (p_pid_version) // R2
    else $error("version flag wrong");
  property p_pid_guard;
    ($changed(pid_low_reg) || $changed(pid_high_reg)) |->
      $past(clr) || ($past(cs_ok) && $past(line_ok));
  endproperty
  a_pid_guard: assert property (p_pid_guard) // R3
    else $error("payload updated without valid checksum or line");
  property p_pid_clear;
    clr |=> pid_low_reg == REG_RESET && pid_high_reg == REG_RESET;
  endproperty
  a_pid_clear: assert property (p_pid_clear) // R5
    else $error("payload bytes not cleared");
  property p_raster_clear;
    clr |=> raster_reg == '0 && !raster_sync_flag;
  endproperty
  a_raster_clear: assert property (p_raster_clear) // R9
    else $error("raster not cleared");
  property p_words;
    eav_ev && !clr |=> raster_reg.total_words == $past(wcnt_reg);
  endproperty
  a_words: assert property (p_words) // R6
    else $error("total words not captured");
  property p_sync_cause;
    $rose(raster_sync_flag) |-> $past(frame_start) && !$past(clr);
  endproperty
  a_sync_cause: assert property (p_sync_cause) // R8
    else $error("sync flag rose without a frame match");
  property p_fmt_unknown;
    fmt_clr |=> fmt_reg == FMT_UNKNOWN;
  endproperty
  a_fmt_unknown: assert property (p_fmt_unknown) // R11
    else $error("format not unknown while cleared");
  property p_fmt_asi;
    !fmt_clr && async_serial_select |=> fmt_reg == FMT_ASI;
  endproperty
  a_fmt_asi: assert property (p_fmt_asi) // R10
    else $error("ASI code missing");
  property p_read_fmt;
    reg_rd && reg_addr == ADDR_DATA_FORMAT |=> reg_rvalid
      && reg_rdata[3:0] == $past(fmt_reg)
      && reg_rdata[DF_SYNC_BIT] == $past(raster_sync_flag);
  endproperty
  a_read_fmt: assert property (p_read_fmt) // R12
    else $error("data format register read wrong");
endmodule // vfd_detector

/* File: pkg/vfd_pkg.sv */
// Shared constants and types for the video format detector
package vfd_pkg;
  // ****************************************************************
  // Stream words and timing reference
  // ****************************************************************
  localparam int          WORD_W    = 10;
  localparam logic [9:0]  W_ONES    = 10'h3FF;
  localparam logic [9:0]  W_ZERO    = 10'h000;
  localparam int          XYZ_F     = 8;
  localparam int          XYZ_V     = 7;
  localparam int          XYZ_H     = 6;
  // Words from SAV id word to the word before next EAV id word that are not active
  localparam logic [12:0] ACT_OFFSET = 13'h0004;

  // ****************************************************************
  // Payload identifier packet
  // ****************************************************************
  localparam logic [7:0]  PID_DID     = 8'h41;
  localparam logic [7:0]  PID_SDID    = 8'h01;
  localparam logic [7:0]  PID_DC      = 8'h04;
  localparam int          PID_VER_BIT = 7;
  localparam logic [10:0] LINES_625   = 11'h271;
  localparam logic [10:0] PID_L525_F1 = 11'h00D;
  localparam logic [10:0] PID_L525_F2 = 11'h114;
  localparam logic [10:0] PID_L625_F1 = 11'h009;
  localparam logic [10:0] PID_L625_F2 = 11'h142;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0]  ADDR_DATA_FORMAT = 8'h04;
  localparam logic [7:0]  ADDR_PID_LOW     = 8'h0F;
  localparam logic [7:0]  ADDR_PID_HIGH    = 8'h10;
  localparam logic [7:0]  ADDR_TOT_LINES   = 8'h11;
  localparam logic [7:0]  ADDR_TOT_WORDS   = 8'h12;
  localparam logic [7:0]  ADDR_ACT_WORDS   = 8'h13;
  localparam logic [7:0]  ADDR_ACT_LINES   = 8'h14;
  localparam int          DF_VER_BIT       = 7;
  localparam int          DF_SYNC_BIT      = 4;
  localparam logic [15:0] REG_RESET        = 16'h0000;

  // ****************************************************************
  // Data format codes
  // ****************************************************************
  localparam logic [3:0] FMT_SDTI_A_NOECC = 4'h0;
  localparam logic [3:0] FMT_SDTI_A_ECC   = 4'h1;
  localparam logic [3:0] FMT_SDTI_B       = 4'h2;
  localparam logic [3:0] FMT_SDTI_CP      = 4'h3;
  localparam logic [3:0] FMT_SDTI_FIXED   = 4'h4;
  localparam logic [3:0] FMT_SDTI_VAR     = 4'h5;
  localparam logic [3:0] FMT_SDI          = 4'h6;
  localparam logic [3:0] FMT_ASI          = 4'h7;
  localparam logic [3:0] FMT_UNKNOWN      = 4'hF;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef struct packed {
    logic [10:0] total_lines;
    logic [12:0] total_words;
    logic [12:0] active_words;
    logic [10:0] active_lines;
  } vfd_raster_t;

  typedef enum logic [2:0] {
    ANC_IDLE, ANC_SDID, ANC_DC, ANC_UDW, ANC_CS
  } vfd_anc_t;
endpackage

/* File: sim/vfd_host_model.sv */
// Host controller model that reads the detector's status registers
`timescale 1ns/1ns

module vfd_host_model (
  input  wire logic       mclk,     // Word clock
  output logic            reg_rd,   // Read strobe
  output logic      [7:0] reg_addr  // Register address
);
  import vfd_pkg::*;

  // ****************************************************************
  // Read requests
  // ****************************************************************
  // Idle bus at time zero
  initial
  begin
    reg_rd   = 1'b0;
    reg_addr = 8'h00;
  end

  // One-cycle strobe; address scrambled after so stale values never pass
  task automatic rd(input logic [7:0] a);
  begin
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
  end
  endtask
endmodule // vfd_host_model

/* File: sim/vfd_detector_tb.sv */
// Self-checking testbench for the video format detector
`timescale 1ns/1ns

module vfd_detector_tb;
  import vfd_pkg::*;

  // ****************************************************************
  // Raster used by the stimulus
  // ****************************************************************
  localparam int NL = 20; // Lines per frame
  localparam int NB = 12; // Blanking words between EAV and SAV
  localparam int NA = 16; // Active words per line
  localparam int NV = 3;  // Blanking lines per field

  logic        mclk;
  logic        rst_b;
  logic        vid_en;
  logic [9:0]  vid_data;
  logic        locked;
  logic        video_processing_select;
  logic        async_serial_select;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic        raster_sync_flag;
  int          mismatches;
  int          checked;
  logic [31:0] exp_q[$];
  logic [31:0] note;
  logic [7:0]  pid[4];
  logic [7:0]  exp_pid[4];

  vfd_detector #(.SYNC_FRAMES(1)) dut (
    .mclk(mclk), .rst_b(rst_b), .vid_en(vid_en), .vid_data(vid_data),
    .locked(locked), .video_processing_select(video_processing_select),
    .async_serial_select(async_serial_select), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .raster_sync_flag(raster_sync_flag)
  );

  vfd_host_model host (.mclk(mclk), .reg_rd(reg_rd), .reg_addr(reg_addr));

  // Free-running word clock
  initial
  begin
    mclk = 1'b0;
  end
  always #5 mclk = ~mclk;

  // ****************************************************************
  // Compare and report
  // ****************************************************************
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
  begin
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t read %h expected %h", $time, got, exp);
    end
  end
  endtask

  task automatic cmp1(input logic got, input logic exp);
  begin
    checked++;
    if (got !== exp)
    begin
      mismatches++;
      $display("FAIL t=%0t sync pin %b expected %b", $time, got, exp);
    end
  end
  endtask

  task automatic results();
  begin
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask

  // Oldest note is matched to each returned word, masked bits ignored
  always @(posedge mclk)
  begin
    if (reg_rvalid === 1'b1)
    begin
      note = exp_q.pop_front();
      cmp16(reg_rdata & note[31:16], note[15:0]);
    end
  end

  // Note the expectation, read, and wait a bounded time for the answer
  task automatic chk(input logic [7:0] a, input logic [15:0] e,
                     input logic [15:0] m);
  begin
    exp_q.push_back({m, e & m});
    host.rd(a);
    for (int i = 0; i < 8 && exp_q.size() != 0; i++)
      @(posedge mclk);
    if (exp_q.size() != 0)
    begin
      mismatches++;
      $display("FAIL t=%0t no read answer", $time);
      results();
    end
  end
  endtask

  // All result registers; on=0 expects the cleared state
  task automatic chk_all(input logic ver, input logic on);
  begin
    chk(ADDR_PID_LOW, on ? {exp_pid[1], exp_pid[0]} : REG_RESET,
        16'hFFFF);
    chk(ADDR_PID_HIGH, on ? {exp_pid[3], exp_pid[2]} : REG_RESET,
        16'hFFFF);
    chk(ADDR_TOT_LINES, on ? 16'(NL) : REG_RESET, 16'hFFFF);
    chk(ADDR_TOT_WORDS, on ? 16'(8 + NB + NA) : REG_RESET,
        16'hFFFF);
    chk(ADDR_ACT_WORDS, on ? 16'(NA) : REG_RESET, 16'hFFFF);
    chk(ADDR_ACT_LINES, on ? 16'(NL / 2 - NV) : REG_RESET,
        16'hFFFF);
    chk(ADDR_DATA_FORMAT, on ? {8'h00, ver, 3'b001, FMT_SDI}
        : {12'h000, FMT_UNKNOWN}, on ? 16'hFFFF : 16'h001F);
    #1 cmp1(raster_sync_flag, on);
  end
  endtask

  // ****************************************************************
  // Video stream drivers
  // ****************************************************************
  task automatic put(input logic [9:0] w);
  begin
    @(posedge mclk);
    vid_en   <= 1'b1;
    vid_data <= w;
  end
  endtask

  // Released data line shows the inverse so stale words never count
  task automatic idle();
  begin
    @(posedge mclk);
    vid_en   <= 1'b0;
    vid_data <= ~vid_data;
  end
  endtask

  task automatic trs(input logic f, input logic v, input logic h);
  begin
    put(W_ONES);
    put(W_ZERO);
    put(W_ZERO);
    put({1'b1, f, v, h, v ^ h, f ^ h, f ^ v, f ^ v ^ h, 2'b00});
  end
  endtask

  // Payload packet; bad flips the checksum's low bit
  task automatic anc(input logic bad);
    logic [8:0] sum;
    logic [9:0] w;
  begin
    put(W_ZERO);
    put(W_ONES);
    put(W_ONES);
    put(10'h241);
    put(10'h101);
    put(10'h104);
    sum = 9'h041 + 9'h101 + 9'h104;
    for (int i = 0; i < 4; i++)
    begin
      w = {~(^pid[i]), ^pid[i], pid[i]};
      sum = sum + w[8:0];
      put(w);
    end
    put({~sum[8], sum[8:1], sum[0] ^ bad});
  end
  endtask

  task automatic line(input logic f, input logic v, input logic pkt,
                      input logic bad);
  begin
    trs(f, v, 1'b1);
    if (pkt)
      anc(bad);
    repeat (pkt ? NB - 11 : NB) put(10'h200);
    trs(f, v, 1'b0);
    repeat (NA) put(10'h010 + 10'($urandom % 32'h3E0));
  end
  endtask

  // Field 1 on lines 1-10, field 2 on 11-20, packet on line pline
  task automatic frame(input int pline, input logic bad);
  begin
    for (int n = 1; n <= NL; n++)
      line(n > NL / 2, ((n - 1) % (NL / 2)) < NV, n == pline, bad);
  end
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial
  begin
    rst_b = 1'b0;
    vid_en = 1'b0;
    vid_data = 10'h000;
    locked = 1'b1;
    video_processing_select = 1'b1;
    async_serial_select = 1'b0;
    mismatches = 0;
    checked = 0;
    void'($urandom(32'hC8180523));
    repeat (12) @(posedge mclk);
    rst_b <= 1'b1;
    chk_all(1'b0, 1'b0);
    chk(8'h20, 16'h0000, 16'hFFFF);
    $display("test reset defaults done");
    // Capture at both versions after the flywheel settles
    for (int v = 0; v < 2; v++)
    begin
      for (int i = 0; i < 4; i++)
        pid[i] = 8'($urandom);
      pid[0][PID_VER_BIT] = v[0];
      repeat (3) frame(0, 1'b0);
      frame(13, 1'b0);
      idle();
      exp_pid = pid;
      chk_all(v[0], 1'b1);
    end
    $display("test capture and geometry done");
    // Bad checksum, then a good packet on the wrong line: no change
    for (int i = 0; i < 4; i++)
      pid[i] = ~exp_pid[i];
    frame(13, 1'b1);
    frame(12, 1'b0);
    idle();
    chk_all(1'b1, 1'b1);
    $display("test refused packets done");
    // Lock loss clears everything
    @(posedge mclk);
    locked <= 1'b0;
    repeat (2) @(posedge mclk);
    chk_all(1'b0, 1'b0);
    // Bypass with serial select gives the serial code
    locked <= 1'b1;
    video_processing_select <= 1'b0;
    async_serial_select <= 1'b1;
    repeat (2) @(posedge mclk);
    chk(ADDR_DATA_FORMAT, {12'h000, FMT_ASI}, 16'h001F);
    // Both selects low: unknown format, all cleared
    async_serial_select <= 1'b0;
    repeat (2) @(posedge mclk);
    chk_all(1'b0, 1'b0);
    $display("test clears and format codes done");
    results();
  end
endmodule // vfd_detector_tb
